// *** hw/bcps_pkg.sv ***
// Constants and types shared by the boot config and partition stats handler
package bcps_pkg;

  // Sizes
  localparam int ADDR_W = 12;
  localparam int MAX_ENTRIES = 32;
  localparam int NUM_PART = 4;
  localparam int PART_W = 2;
  localparam int IDX_W = 6;
  localparam int ATTR_W = 6;
  localparam int STORE_DEPTH = 256;
  localparam logic [IDX_W-1:0] MAX_ENTRIES_IDX = 6'h20;

  // Command and response type codes
  localparam logic [7:0] CMD_SET_BOOT = 8'h2E;
  localparam logic [7:0] RSP_SET_BOOT = 8'hAE;
  localparam logic [7:0] CMD_GET_STATS = 8'h2F;
  localparam logic [7:0] RSP_TYPE_FLAG = 8'h80;

  // Response codes and reasons
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_FAIL = 8'h01;
  localparam logic [7:0] RC_UNSUP = 8'h03;
  localparam logic [15:0] REASON_NONE = 16'h0000;
  localparam logic [15:0] REASON_BAD_PARAM = 16'h0002;

  // Boot protocol selector
  localparam logic [7:0] PROTO_PXE = 8'h00;
  localparam logic [7:0] PROTO_ISCSI = 8'h01;
  localparam logic [7:0] PROTO_FCOE = 8'h02;
  localparam logic [7:0] PROTO_FC = 8'h03;
  localparam logic [7:0] PROTO_NVMEOFC = 8'h04;
  localparam int NUM_PROTO = 5;

  // Attribute type ranges per protocol and largest value length in bytes
  localparam logic [7:0] PXE_TYPE_MAX = 8'h02;
  localparam logic [7:0] FC_TYPE_MAX = 8'h04;
  localparam logic [7:0] ISCSI_A_MAX = 8'h07;
  localparam logic [7:0] ISCSI_B_LO = 8'h10;
  localparam logic [7:0] ISCSI_B_MAX = 8'h18;
  localparam logic [7:0] ISCSI_C_LO = 8'h20;
  localparam logic [7:0] ISCSI_C_MAX = 8'h28;
  localparam logic [7:0] MAX_VAL_BYTES = 8'h04;

  // Statistics kinds
  localparam logic [7:0] KIND_ETH = 8'h01;
  localparam logic [7:0] KIND_ISCSI = 8'h02;
  localparam logic [7:0] KIND_FCOE = 8'h04;
  localparam logic [7:0] KIND_RDMA = 8'h08;
  localparam logic [7:0] KIND_IB = 8'h10;
  localparam logic [31:0] ONES32 = 32'hFFFFFFFF;

  // Field positions
  localparam int ARG_PART_LSB = 24;
  localparam int ARG_PROTO_LSB = 8;
  localparam int ARG_COUNT_LSB = 0;
  localparam int ARG_KIND_LSB = 0;
  localparam int TL_LEN_LSB = 8;
  localparam int RSP_TYPE_LSB = 24;
  localparam int RSP_CODE_LSB = 16;
  localparam int CFG_PART_EN_BIT = 0;
  localparam int CFG_SUP_LSB = 8;
  localparam int CFG_EXIST_LSB = 16;
  localparam int CFG_RX_SUP_BIT = 24;
  localparam int CFG_TX_SUP_BIT = 25;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_W = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] A_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] A_ARG = 12'h004;
  localparam logic [ADDR_W-1:0] A_ENT_VAL = 12'h008;
  localparam logic [ADDR_W-1:0] A_ENT_TL = 12'h00C;
  localparam logic [ADDR_W-1:0] A_RSP = 12'h010;
  localparam logic [ADDR_W-1:0] A_BITMAP = 12'h014;
  localparam logic [ADDR_W-1:0] A_RX_HI = 12'h018;
  localparam logic [ADDR_W-1:0] A_RX_LO = 12'h01C;
  localparam logic [ADDR_W-1:0] A_TX_HI = 12'h020;
  localparam logic [ADDR_W-1:0] A_TX_LO = 12'h024;
  localparam logic [ADDR_W-1:0] A_CFG = 12'h028;
  localparam logic [ADDR_W-1:0] A_PERSONA = 12'h02C;
  localparam logic [ADDR_W-1:0] A_ST_IDX = 12'h030;
  localparam logic [ADDR_W-1:0] A_ST_VAL = 12'h034;
  localparam logic [ADDR_W-1:0] A_ST_LEN = 12'h038;
  localparam logic [ADDR_W-1:0] A_IRQ_ST = 12'h03C;
  localparam logic [ADDR_W-1:0] A_IRQ_EN = 12'h040;
  localparam logic [ADDR_W-1:0] A_IRQ_CLR = 12'h044;
  localparam logic [31:0] REG_RST = 32'h00000000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CHECK = 4'h2,
    ST_COMMIT = 4'h4,
    ST_REPORT = 4'h8
  } bcps_state_e;

endpackage

// *** hw/bcps_entry_check.sv ***
// Validity check of one attribute entry against its boot protocol
`timescale 1ns/1ns
module bcps_entry_check
  import bcps_pkg::*;
(
  input wire logic [7:0] proto,
  input wire logic [7:0] etype,
  input wire logic [7:0] elen,
  output logic bad
);
  logic type_ok;

  // Known attribute types per protocol; values wider than one word are refused
  always_comb
  begin
    type_ok = 1'b0;
    case (proto)
      PROTO_PXE: type_ok = (etype <= PXE_TYPE_MAX);
      PROTO_ISCSI: type_ok = (etype <= ISCSI_A_MAX) ||
                             (etype >= ISCSI_B_LO && etype <= ISCSI_B_MAX) ||
                             (etype >= ISCSI_C_LO && etype <= ISCSI_C_MAX);
      PROTO_FCOE, PROTO_FC, PROTO_NVMEOFC: type_ok = (etype <= FC_TYPE_MAX);
      default: type_ok = 1'b0;
    endcase
    bad = !type_ok || (elen > MAX_VAL_BYTES);
  end
endmodule

// *** hw/bcps_top.sv ***
// Boot settings write and partition statistics command handler, APB slave
//
// Function
// - Boot settings write is code 0x2E; success answers with type 0xAE.
// - Attribute entries are committed strictly in arrival order.
// - An entry of length zero clears the attribute to no value.
// - Unsupported boot protocol at an existing target answers unsupported.
// - Every boot settings write gets a response.
// - Any bad entry rejects the whole write; stored settings stay unchanged.
// - Response carries a 32-bit per-entry error bitmap, bit 0 first entry.
// - Bitmap bits past the entry count read zero; counted entries never received read one.
// - Argument word holds partition index, protocol and entry count.
// - Statistics query is 0x2F; partition first byte, kind last byte.
// - Kind codes 0x01,0x02,0x04,0x08,0x10; all others reserved.
// - Statistics query exists only while partitioning is supported.
// - Unsupported counters return all ones.
// - Missing partition or kind mismatch fails with bad parameter reason.
// - Protocol codes 0x0 to 0x4; higher values reserved.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module bcps_top
  import bcps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bcps_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] rx_bytes,
  input wire logic [63:0] tx_bytes,
  output logic [bcps_pkg::PART_W-1:0] stats_part,
  output logic irq
);
  import bcps_pkg::*;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  bcps_state_e state_q, state_d;
  logic [31:0] arg_q, arg_d, val_q, val_d, cfg_q, cfg_d, persona_q, persona_d;
  logic [31:0] rsp_q, rsp_d, bitmap_q, bitmap_d, prdata_q, prdata_d;
  logic [63:0] rx_q, rx_d, tx_q, tx_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] st_idx_q, st_idx_d;
  logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d, irq_set;
  logic [IDX_W-1:0] npush_q, npush_d, idx_q, idx_d;
  logic [PART_W-1:0] part_q, part_d;
  logic pslverr_q, pslverr_d;
  logic wr, setup, push, start;
  logic [7:0] ent_type [MAX_ENTRIES];
  logic [7:0] ent_len [MAX_ENTRIES];
  logic [31:0] ent_val [MAX_ENTRIES];
  logic [31:0] st_val [STORE_DEPTH];
  logic [7:0] st_len [STORE_DEPTH];
  logic [7:0] st_proto [NUM_PART];
  logic st_we;
  logic [7:0] st_waddr, st_wlen;
  logic [31:0] st_wval;
  logic [7:0] a_part, a_proto, a_count, a_kind, cur_kind;
  logic [4:0] cur;
  logic ent_bad, part_ok, proto_ok, kind_ok;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign pready = psel && penable;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign irq = |(irq_st_q & irq_en_q);
  assign stats_part = part_q;

  // Argument word fields
  // argument word layout
  assign a_part = arg_q[ARG_PART_LSB +: 8];
  assign a_proto = arg_q[ARG_PROTO_LSB +: 8];
  assign a_count = arg_q[ARG_COUNT_LSB +: 8];
  assign a_kind = arg_q[ARG_KIND_LSB +: 8];
  assign cur = idx_q[4:0];
  assign cur_kind = persona_q[8*a_part[PART_W-1:0] +: 8];

  // Read data and error are latched in the setup phase, so access needs no wait
  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup)
    begin
      prdata_d = REG_RST;
      pslverr_d = 1'b0;
      if (paddr == A_CMD)
        prdata_d = {24'h000000, cmd_q[7:1], state_q != ST_IDLE};
      else if (paddr == A_ARG)
        prdata_d = arg_q;
      else if (paddr == A_ENT_VAL)
        prdata_d = val_q;
      else if (paddr == A_ENT_TL)
        prdata_d = {26'h0000000, npush_q};
      else if (paddr == A_RSP)
        prdata_d = rsp_q;
      else if (paddr == A_BITMAP)
        prdata_d = bitmap_q;
      else if (paddr == A_RX_HI)
        prdata_d = rx_q[63:32];
      else if (paddr == A_RX_LO)
        prdata_d = rx_q[31:0];
      else if (paddr == A_TX_HI)
        prdata_d = tx_q[63:32];
      else if (paddr == A_TX_LO)
        prdata_d = tx_q[31:0];
      else if (paddr == A_CFG)
        prdata_d = cfg_q;
      else if (paddr == A_PERSONA)
        prdata_d = persona_q;
      else if (paddr == A_ST_IDX)
        prdata_d = {24'h000000, st_idx_q};
      else if (paddr == A_ST_VAL)
        prdata_d = st_val[st_idx_q];
      else if (paddr == A_ST_LEN)
        prdata_d = {16'h0000, st_proto[st_idx_q[7:6]], st_len[st_idx_q]};
      else if (paddr == A_IRQ_ST)
        prdata_d = {30'h00000000, irq_st_q};
      else if (paddr == A_IRQ_EN)
        prdata_d = {30'h00000000, irq_en_q};
      else if (paddr == A_IRQ_CLR)
        prdata_d = REG_RST;
      else
        pslverr_d = 1'b1;
    end
  end

  // Software-written registers; command and entry writes refused while busy
  always_comb
  begin
    arg_d = arg_q;
    val_d = val_q;
    cfg_d = cfg_q;
    persona_d = persona_q;
    st_idx_d = st_idx_q;
    irq_en_d = irq_en_q;
    push = 1'b0;
    start = 1'b0;
    if (wr)
    begin
      if (paddr == A_CMD)
        start = (state_q == ST_IDLE);
      else if (paddr == A_ARG && state_q == ST_IDLE)
        arg_d = pwdata;
      else if (paddr == A_ENT_VAL && state_q == ST_IDLE)
        val_d = pwdata;
      else if (paddr == A_ENT_TL)
        push = (state_q == ST_IDLE) && (npush_q < MAX_ENTRIES_IDX);
      else if (paddr == A_CFG)
        cfg_d = pwdata;
      else if (paddr == A_PERSONA)
        persona_d = pwdata;
      else if (paddr == A_ST_IDX)
        st_idx_d = pwdata[7:0];
      else if (paddr == A_IRQ_EN)
        irq_en_d = pwdata[IRQ_W-1:0];
    end
  end

  // Sticky status; a new event outranks a clear in the same cycle
  always_comb
  begin
    irq_st_d = irq_st_q;
    if (wr && paddr == A_IRQ_CLR)
      irq_st_d = irq_st_q & ~pwdata[IRQ_W-1:0];
    irq_st_d = irq_st_d | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arg_q <= REG_RST;
      val_q <= REG_RST;
      cfg_q <= REG_RST;
      persona_q <= REG_RST;
      st_idx_q <= '0;
      irq_en_q <= '0;
      irq_st_q <= '0;
      prdata_q <= REG_RST;
      pslverr_q <= 1'b0;
    end
    else
    begin
      arg_q <= arg_d;
      val_q <= val_d;
      cfg_q <= cfg_d;
      persona_q <= persona_d;
      st_idx_q <= st_idx_d;
      irq_en_q <= irq_en_d;
      irq_st_q <= irq_st_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ------------------------------------------------------------
  // Entry staging and stored settings
  // ------------------------------------------------------------
  // Staging array has no reset; only entries below the push count are read
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      ent_type[npush_q[4:0]] <= pwdata[7:0];
      ent_len[npush_q[4:0]] <= pwdata[TL_LEN_LSB +: 8];
      ent_val[npush_q[4:0]] <= val_q;
    end
  end

  // Store is cleared by reset so an unset attribute reads empty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < STORE_DEPTH; i++)
      begin
        st_val[i] <= REG_RST;
        st_len[i] <= 8'h00;
      end
      for (int p = 0; p < NUM_PART; p++)
        st_proto[p] <= PROTO_PXE;
    end
    else if (st_we)
    begin
      st_val[st_waddr] <= st_wval;
      st_len[st_waddr] <= st_wlen;
      st_proto[part_q] <= a_proto;
    end
  end

  bcps_entry_check u_check (
    .proto(a_proto),
    .etype(ent_type[cur]),
    .elen(ent_len[cur]),
    .bad(ent_bad)
  );

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  // partitioning enable and existing partitions
  assign part_ok = (a_part < NUM_PART) && cfg_q[CFG_EXIST_LSB + a_part[PART_W-1:0]] &&
                   (cfg_q[CFG_PART_EN_BIT] || a_part == 8'h00);
  assign proto_ok = (a_proto < NUM_PROTO) && cfg_q[CFG_SUP_LSB + a_proto[2:0]];
  assign kind_ok = (a_kind == KIND_ETH || a_kind == KIND_ISCSI || a_kind == KIND_FCOE ||
                    a_kind == KIND_RDMA || a_kind == KIND_IB) && (a_kind == cur_kind);

  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    npush_d = push ? npush_q + 6'h01 : npush_q;
    cmd_d = cmd_q;
    rsp_d = rsp_q;
    bitmap_d = bitmap_q;
    rx_d = rx_q;
    tx_d = tx_q;
    part_d = part_q;
    irq_set = '0;
    st_we = 1'b0;
    st_waddr = {part_q, ent_type[cur][ATTR_W-1:0]};
    st_wlen = ent_len[cur];
    st_wval = REG_RST;
    case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          cmd_d = pwdata[7:0];
          part_d = a_part[PART_W-1:0];
          idx_d = '0;
          bitmap_d = REG_RST;
          state_d = ST_REPORT;
          rsp_d = {pwdata[7:0] | RSP_TYPE_FLAG, RC_UNSUP, REASON_NONE};
          if (pwdata[7:0] == CMD_SET_BOOT)
          begin
            if (!part_ok || a_count > MAX_ENTRIES)
              rsp_d = {RSP_SET_BOOT, RC_FAIL, REASON_BAD_PARAM};
            else if (!proto_ok)
              rsp_d = {RSP_SET_BOOT, RC_UNSUP, REASON_NONE};
            else
              state_d = ST_CHECK;
          end
          else if (pwdata[7:0] == CMD_GET_STATS && cfg_q[CFG_PART_EN_BIT])
          begin
            if (!part_ok || !kind_ok)
              rsp_d = {CMD_GET_STATS | RSP_TYPE_FLAG, RC_FAIL, REASON_BAD_PARAM};
            else
              rsp_d = {CMD_GET_STATS | RSP_TYPE_FLAG, RC_OK, REASON_NONE};
          end
        end
      end
      ST_CHECK:
      begin
        // bits past the count stay zero
        if (idx_q == a_count[IDX_W-1:0])
        begin
          idx_d = '0;
          // any bad entry rejects the whole write
          if (bitmap_q != REG_RST)
          begin
            state_d = ST_REPORT;
            rsp_d = {RSP_SET_BOOT, RC_FAIL, REASON_BAD_PARAM};
          end
          else
            state_d = ST_COMMIT;
        end
        else
        begin
          bitmap_d[cur] = ent_bad || (idx_q >= npush_q);
          idx_d = idx_q + 6'h01;
        end
      end
      ST_COMMIT:
      begin
        // one entry per cycle in arrival order
        if (idx_q == a_count[IDX_W-1:0])
        begin
          state_d = ST_REPORT;
          rsp_d = {RSP_SET_BOOT, RC_OK, REASON_NONE};
        end
        else
        begin
          st_we = 1'b1;
          st_wval = (ent_len[cur] == 8'h00) ? REG_RST : ent_val[cur];
          idx_d = idx_q + 6'h01;
        end
      end
      ST_REPORT:
      begin
        // every command ends in a response event
        irq_set[IRQ_DONE] = 1'b1;
        irq_set[IRQ_FAIL] = (rsp_q[RSP_CODE_LSB +: 8] != RC_OK);
        // all ones for unsupported counters
        // Sampled here, where stats_part already names the queried partition
        if (cmd_q == CMD_GET_STATS && rsp_q[RSP_CODE_LSB +: 8] == RC_OK)
        begin
          rx_d = cfg_q[CFG_RX_SUP_BIT] ? rx_bytes : {ONES32, ONES32};
          tx_d = cfg_q[CFG_TX_SUP_BIT] ? tx_bytes : {ONES32, ONES32};
        end
        npush_d = '0;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      npush_q <= '0;
      cmd_q <= 8'h00;
      rsp_q <= REG_RST;
      bitmap_q <= REG_RST;
      rx_q <= '0;
      tx_q <= '0;
      part_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      npush_q <= npush_d;
      cmd_q <= cmd_d;
      rsp_q <= rsp_d;
      bitmap_q <= bitmap_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      part_q <= part_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_set_rsp_type: assert property (
    state_q == ST_REPORT && cmd_q == CMD_SET_BOOT |-> rsp_q[RSP_TYPE_LSB +: 8] == RSP_SET_BOOT)
    else $error("boot write answered with wrong type");
  a_commit_order: assert property (
    st_we |=> idx_q == $past(idx_q) + 6'h01 && state_q == ST_COMMIT || state_q == ST_REPORT)
    else $error("commit did not advance one entry");
  a_zero_clears: assert property (
    st_we && st_wlen == 8'h00 |=> st_val[$past(st_waddr)] == REG_RST)
    else $error("zero length entry kept a value");
  a_unsup_proto: assert property (
    start && pwdata[7:0] == CMD_SET_BOOT && part_ok && a_count <= MAX_ENTRIES && !proto_ok
    |=> state_q == ST_REPORT && rsp_q[RSP_CODE_LSB +: 8] == RC_UNSUP)
    else $error("unsupported protocol not reported");
  a_always_answer: assert property (
    start |-> ##[1:80] irq_st_q[IRQ_DONE])
    else $error("command never answered");
  a_no_partial: assert property (
    st_we |-> bitmap_q == REG_RST && state_q == ST_COMMIT)
    else $error("store written after an entry error");
  a_bitmap_unsent: assert property (
    state_q == ST_REPORT && cmd_q == CMD_SET_BOOT && a_count < MAX_ENTRIES
    |-> (bitmap_q >> a_count) == REG_RST)
    else $error("bitmap bit set past entry count");
  a_stats_ones: assert property (
    start && pwdata[7:0] == CMD_GET_STATS && cfg_q[CFG_PART_EN_BIT] && part_ok && kind_ok
    && !cfg_q[CFG_RX_SUP_BIT] |=> ##1 rx_q == {ONES32, ONES32})
    else $error("unsupported counter not all ones");
  a_stats_bad: assert property (
    start && pwdata[7:0] == CMD_GET_STATS && cfg_q[CFG_PART_EN_BIT] && !kind_ok
    |=> rsp_q[15:0] == REASON_BAD_PARAM ##1 irq_st_q[IRQ_FAIL])
    else $error("kind mismatch not refused");

  c_set_ok: cover property (state_q == ST_COMMIT ##[1:40] state_q == ST_REPORT);
  c_set_fail: cover property (state_q == ST_CHECK && bitmap_q != REG_RST);
  c_stats_ok: cover property (start && pwdata[7:0] == CMD_GET_STATS ##1
    rsp_q[RSP_CODE_LSB +: 8] == RC_OK);
endmodule

// *** bench/bcps_counter_model.sv ***
// Far-side counter source feeding the statistics query
`timescale 1ns/1ns
module bcps_counter_model
  import bcps_pkg::*;
(
  input wire logic [bcps_pkg::PART_W-1:0] stats_part,
  output logic [63:0] rx_bytes,
  output logic [63:0] tx_bytes
);
  // Values keyed by partition, so a wrong selection shows in the result
  assign rx_bytes = {32'h000000A0, 30'h30DE0000, stats_part};
  assign tx_bytes = {32'h000000B0, 30'h00000000, stats_part};
endmodule

// *** bench/tb_boot_config_partition_stats.sv ***
// Self-checking bench for the boot settings and partition statistics handler
`timescale 1ns/1ns
module tb_boot_config_partition_stats;
  import bcps_pkg::*;
  typedef struct {
    logic [31:0] arg;
    logic [7:0] cmd;
    logic [15:0] tl0;
    logic [15:0] tl1;
    logic [31:0] rsp;
    logic [7:0] bmp;
  } bcps_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [63:0] rx_bytes;
  logic [63:0] tx_bytes;
  logic [PART_W-1:0] stats_part;
  logic irq;
  logic [31:0] rdat;
  logic err;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  // rows 5 and 18 ask each partition for its configured kind
  bcps_row_s rows [19] = '{
    '{32'h00000002, 8'h2E, 16'h0200, 16'h0100, 32'hAE000000, 8'h00},
    '{32'h00000002, 8'h2E, 16'h0300, 16'h0105, 32'hAE010002, 8'h02},
    '{32'h00000200, 8'h2E, 16'h0000, 16'h0000, 32'hAE030000, 8'h00},
    '{32'h00000001, 8'h2E, 16'h0500, 16'h0000, 32'hAE010002, 8'h01},
    '{32'h00000002, 8'h2E, 16'h0101, 16'h0001, 32'hAE000000, 8'h00},
    '{32'h00000001, 8'h2F, 16'h0000, 16'h0000, 32'hAF000000, 8'h00},
    '{32'h03000000, 8'h2E, 16'h0000, 16'h0000, 32'hAE010002, 8'h00},
    '{32'h01000001, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h02000001, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h00000002, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h00000004, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h00000008, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h00000010, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h00000003, 8'h2F, 16'h0000, 16'h0000, 32'hAF010002, 8'h00},
    '{32'h00000000, 8'h30, 16'h0000, 16'h0000, 32'hB0030000, 8'h00},
    '{32'h00000100, 8'h2E, 16'h0000, 16'h0000, 32'hAE000000, 8'h00},
    '{32'h00000300, 8'h2E, 16'h0000, 16'h0000, 32'hAE030000, 8'h00},
    '{32'h00000400, 8'h2E, 16'h0000, 16'h0000, 32'hAE030000, 8'h00},
    '{32'h01000002, 8'h2F, 16'h0000, 16'h0000, 32'hAF000000, 8'h00}
  };

  bcps_top uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_bytes(rx_bytes),
    .tx_bytes(tx_bytes),
    .stats_part(stats_part),
    .irq(irq)
  );

  bcps_counter_model far (
    .stats_part(stats_part),
    .rx_bytes(rx_bytes),
    .tx_bytes(tx_bytes)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    forever #2 pclk = ~pclk;
  end

  // Whole run needs under a thousand cycles; far past that means a hang
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; an idle edge first keeps back-to-back calls legal
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(name, rdat, exp);
  endtask

  // Stage argument and entries, start, then poll the done bit
  task automatic run_cmd(input bcps_row_s r);
    apb(1'b1, A_ARG, r.arg);
    if (r.cmd === 8'h2E)
      for (int i = 0; i < int'(r.arg[7:0]); i++)
      begin
        apb(1'b1, A_ENT_VAL, 32'h00000030 + i);
        apb(1'b1, A_ENT_TL, {16'h0000, (i == 0) ? r.tl0 : r.tl1});
      end
    apb(1'b1, A_CMD, {24'h000000, r.cmd});
    rdat = 32'h00000000;
    while (rdat[0] !== 1'b1)
      apb(1'b0, A_IRQ_ST, 32'h00000000);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Partitions 0,1 exist; PXE and iSCSI boot; only rx counter kept
    apb(1'b1, A_CFG, 32'h01030301);
    apb(1'b1, A_PERSONA, 32'h00000201);
    apb(1'b1, A_IRQ_EN, 32'h00000003);
    foreach (rows[i])
    begin
      run_cmd(rows[i]);
      chk("irq", {31'h0, irq}, 32'h00000001);
      rchk("irq_st", A_IRQ_ST, (rows[i].rsp[23:16] != 8'h00) ? 32'h3 : 32'h1);
      rchk("rsp", A_RSP, rows[i].rsp);
      if (rows[i].cmd === 8'h2E)
        rchk("bitmap", A_BITMAP, {24'h0, rows[i].bmp});
      if (rows[i].rsp === 32'hAF000000)
      begin
        rchk("rx_hi", A_RX_HI, 32'h000000A0);
        rchk("rx_lo", A_RX_LO, 32'hC3780000 + {30'h0, rows[i].arg[25:24]});
        rchk("tx_hi", A_TX_HI, 32'hFFFFFFFF);
        rchk("tx_lo", A_TX_LO, 32'hFFFFFFFF);
        chk("stats_part", {30'h0, stats_part}, {30'h0, rows[i].arg[25:24]});
      end
      apb(1'b1, A_IRQ_CLR, 32'h00000003);
      rchk("irq_clr", A_IRQ_ST, 32'h00000000);
      chk("irq_low", {31'h0, irq}, 32'h00000000);
      $display("row %0d done", i);
    end
    // Later entry wins; the rejected writes left attribute 0 alone
    apb(1'b1, A_ST_IDX, 32'h00000000);
    rchk("st_val0", A_ST_VAL, 32'h00000031);
    rchk("st_len0", A_ST_LEN, 32'h00000001);
    apb(1'b1, A_ST_IDX, 32'h00000001);
    rchk("st_val1", A_ST_VAL, 32'h00000000);
    rchk("st_len1", A_ST_LEN, 32'h00000000);
    $display("store test done");
    // Masked event stays pending until enabled
    apb(1'b1, A_IRQ_EN, 32'h00000000);
    run_cmd(rows[5]);
    chk("irq_masked", {31'h0, irq}, 32'h00000000);
    apb(1'b1, A_IRQ_EN, 32'h00000001);
    rchk("irq_en", A_IRQ_EN, 32'h00000001);
    chk("irq_unmasked", {31'h0, irq}, 32'h00000001);
    $display("mask test done");
    // Receive counter dropped answers all ones; then partitioning off
    apb(1'b1, A_IRQ_CLR, 32'h00000003);
    apb(1'b1, A_CFG, 32'h00030301);
    run_cmd(rows[5]);
    rchk("rx_ones", A_RX_LO, 32'hFFFFFFFF);
    apb(1'b1, A_IRQ_CLR, 32'h00000003);
    apb(1'b1, A_CFG, 32'h01030300);
    run_cmd(rows[15]);
    rchk("rsp_nopart", A_RSP, 32'hAE000000);
    apb(1'b1, A_IRQ_CLR, 32'h00000003);
    run_cmd(rows[5]);
    rchk("rsp_nostats", A_RSP, 32'hAF030000);
    $display("config test done");
    // Unmapped place answers with an error
    apb(1'b0, 12'h100, 32'h00000000);
    chk("unmapped_data", rdat, 32'h00000000);
    chk("unmapped_err", {31'h0, err}, 32'h00000001);
    $display("unmapped test done");
    // Second reset in mid-run clears the registers and the store; the staging array keeps its data
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("cfg_rst", A_CFG, 32'h00000000);
    rchk("rsp_rst", A_RSP, 32'h00000000);
    rchk("irq_st_rst", A_IRQ_ST, 32'h00000000);
    rchk("st_rst", A_ST_VAL, 32'h00000000);
    chk("irq_rst", {31'h0, irq}, 32'h00000000);
    $display("reset test done");
    report_and_stop();
  end
endmodule
